// *** rtl/prsi_sequencer.sv ***
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - eight return address stack entries
// - push pc on interrupt, call, table reference
// - level pointer wraps seven to zero, overwrites
// - three bit level pointer, readable by instruction
// - context saved only on interrupt entry
// - skip flag saved with interrupt context
// - pc steps by length or loads target
// - page bits above in-page seven bits
// - ram address from group, file, digit
// - ten bit words, 128 word pages
// - vectors in page one upper half
// - one word call into page two
// - table reference returns low eight bits
// - bank bit picks upper or lower pages for table reference
// - four bit ram words, bit operations
// - interrupt needs flag, enable, global enable
// - global enable set and cleared by instructions
// - taking interrupt clears global enable
// - enable bit picks interrupt or skip use
// - request flag sticky until taken or skipped
// - pending flag fires on release, fixed priority
// - pointer registers need software initialisation; here reset clears dp to zero
// - entry clears only the served flag
// - entry two to three machine cycles later
// - enable acts after one further instruction
module prsi_sequencer
    import prsi_pkg::*;
#(
    parameter int DEPTH   = STACK_DEPTH,
    parameter int SOURCES = NUM_SRC
) (
    input  wire logic              pclk,              // clock
    input  wire logic              presetn,           // async reset, low
    input  wire logic              psel,              // apb select
    input  wire logic              penable,           // apb enable
    input  wire logic              pwrite,            // apb direction
    input  wire logic [APB_AW-1:0] paddr,             // apb byte address
    input  wire logic [31:0]       pwdata,            // apb write data
    output logic      [31:0]       prdata,            // apb read data
    output logic                   pready,            // apb ready
    output logic                   pslverr,           // apb error
    input  wire logic              mc_tick,           // machine cycle enable
    input  wire logic              instr_valid,       // instruction completes
    input  wire prsi_instr_t       instr,             // decoded instruction
    input  wire prsi_ctx_t         cur_ctx,           // live alu context
    input  wire logic [NUM_SRC-1:0] src_event,        // activation pulses
    input  wire logic [ROM_W-1:0]  rom_word,          // word at pc
    output logic      [PC_W-1:0]   pc,                // program counter
    output prsi_dp_t               ram_addr,          // ram pointer
    output logic      [RAM_W-1:0]  ram_bit_mask,      // bit select
    output logic      [TBL_W-1:0]  table_data,        // table reference data
    output logic                   table_valid,       // table data pulse
    output logic                   skip_taken,        // skip decision pulse
    output logic      [SP_W-1:0]   sp_level,          // level for accumulator
    output prsi_ctx_t              ctx_restore,       // restored context
    output logic                   ctx_restore_valid, // restore pulse
    output logic                   int_taken          // entry pulse
);

    if (DEPTH != STACK_DEPTH || SOURCES != NUM_SRC) begin : g_check
        $error("prsi_sequencer: unsupported depth or source count");
    end

    function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] p,
                                               input logic [1:0] n);
        pc_add = p + {{(PC_W-2){1'b0}}, n};
    endfunction

    function automatic logic [SRC_W-1:0] prio(input logic [NUM_SRC-1:0] v);
        prio = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                prio = SRC_W'(i);
            end
        end
    endfunction

    function automatic logic [RAM_W-1:0] bit_mask(input logic [1:0] j);
        bit_mask = 4'h1 << j;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [PC_W-1:0]    stack_mem [STACK_DEPTH];
    logic [SP_W-1:0]    sp;
    prsi_dp_t           dp;
    prsi_ctx_t          ctx_save;
    logic               gie;
    logic               ei_arm;
    logic               bank;
    logic               tbl_pending;
    logic [NUM_SRC-1:0] req_flag;
    logic [GRP_W-1:0]   enable_group_one;
    logic [GRP_W-1:0]   enable_group_two;
    prsi_state_t        state;
    logic [1:0]         lat_cnt;
    logic               lat_long;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire [NUM_SRC-1:0] en_bits   = {enable_group_two, enable_group_one};
    wire [NUM_SRC-1:0] active    = req_flag & en_bits & {NUM_SRC{gie}};
    wire               any_req   = |active;
    wire [SRC_W-1:0]   serve     = prio(active);
    wire [1:0]         need      = lat_long ? LAT_LONG : LAT_SHORT;
    // at or past the target: a table fetch may hold entry off for a tick
    wire               int_enter = (state == ST_WAIT) & mc_tick & any_req
                                   & (lat_cnt >= need) & ~tbl_pending;
    wire               exec      = mc_tick & instr_valid & ~int_enter & ~tbl_pending;
    wire               tbl_done  = mc_tick & tbl_pending;
    wire prsi_op_t     op        = instr.op;
    wire [PC_W-1:0]    pc_step   = pc_add(pc, instr.len);
    wire [SP_W-1:0]    sp_up     = sp + 3'h1;
    wire [SP_W-1:0]    sp_dn     = sp - 3'h1;
    wire [PC_W-1:0]    top       = stack_mem[sp];
    wire               is_call   = (op == OP_CALL) | (op == OP_PAGE2_CALL);
    wire               do_push   = int_enter | exec & (is_call | op == OP_TABLE_REF);
    wire               do_pop    = tbl_done | exec & (op == OP_RETURN | op == OP_INT_RETURN);
    wire [PC_W-1:0]    push_val  = int_enter ? pc : pc_step;
    wire [PC_W-1:0]    vec_addr  = VECTOR_BASE | {{(PC_W-SRC_W-1){1'b0}}, serve, 1'b0};
    wire [PC_W-1:0]    page2_adr = PAGE2_BASE | {{PAGE_W{1'b0}}, instr.target[6:0]};
    wire [PC_W-1:0]    tbl_adr   = {bank, instr.tbl_page, instr.tbl_addr};
    wire               skip_ok   = ~en_bits[instr.src] & req_flag[instr.src];
    wire               skip_hit  = exec & (op == OP_SKIP_TEST) & skip_ok;

    wire [PC_W-1:0] next_pc =
        int_enter                       ? vec_addr  :
        tbl_done                        ? top       :
        ~exec                           ? pc        :
        (op == OP_BRANCH | op == OP_CALL) ? instr.target :
        (op == OP_PAGE2_CALL)           ? page2_adr :
        (op == OP_RETURN | op == OP_INT_RETURN) ? top :
        (op == OP_TABLE_REF)            ? tbl_adr   : pc_step;

    wire [NUM_SRC-1:0] clr_mask =
        ({NUM_SRC{int_enter}} & (NUM_SRC'(1) << serve))
        | ({NUM_SRC{skip_hit}} & (NUM_SRC'(1) << instr.src));
    wire [NUM_SRC-1:0] next_req = src_event | (req_flag & ~clr_mask);

    ////////////////////////////////////////////////////////////////////////
    // program counter and stack

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_RESET;
            sp <= SP_RESET;
        end else begin
            pc <= next_pc;
            if (do_push) begin
                sp <= sp_up;
            end else if (do_pop) begin
                sp <= sp_dn;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (do_push) begin
            stack_mem[sp_up] <= push_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data pointer, context, table reference

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp                <= '0;
            ctx_save          <= '0;
            ctx_restore       <= '0;
            ctx_restore_valid <= 1'b0;
            tbl_pending       <= 1'b0;
            table_data        <= '0;
            table_valid       <= 1'b0;
            sp_level          <= '0;
            ram_bit_mask      <= '0;
            skip_taken        <= 1'b0;
            int_taken         <= 1'b0;
            bank              <= 1'b0;
        end else begin
            ctx_restore_valid <= 1'b0;
            table_valid       <= 1'b0;
            skip_taken        <= skip_hit;
            int_taken         <= int_enter;
            if (int_enter) begin
                ctx_save    <= cur_ctx;
                ctx_save.dp <= dp;
            end
            if (tbl_done) begin
                tbl_pending <= 1'b0;
                table_data  <= rom_word[TBL_W-1:0];
                table_valid <= 1'b1;
            end
            if (exec) begin
                ram_bit_mask <= bit_mask(instr.bit_idx);
                case (op)
                    OP_LOAD_DP:    dp <= instr.dp;
                    OP_TABLE_REF:  tbl_pending <= 1'b1;
                    OP_READ_SP:    sp_level <= sp;
                    OP_SET_BANK:   bank <= 1'b1;
                    OP_CLR_BANK:   bank <= 1'b0;
                    OP_INT_RETURN: begin
                        dp                <= ctx_save.dp;
                        ctx_restore       <= ctx_save;
                        ctx_restore_valid <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign ram_addr = dp;

    ////////////////////////////////////////////////////////////////////////
    // interrupt gating and latency

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie      <= 1'b0;
            ei_arm   <= 1'b0;
            req_flag <= '0;
            state    <= ST_IDLE;
            lat_cnt  <= '0;
            lat_long <= 1'b0;
        end else begin
            req_flag <= next_req;
            if (int_enter) begin
                gie    <= 1'b0;
                ei_arm <= 1'b0;
            end else if (exec) begin
                if (op == OP_EI) begin
                    ei_arm <= 1'b1;
                end else if (op == OP_DI) begin
                    gie    <= 1'b0;
                    ei_arm <= 1'b0;
                end else if (ei_arm) begin
                    gie    <= 1'b1;
                    ei_arm <= 1'b0;
                end
            end
            if (mc_tick) begin
                case (state)
                    ST_IDLE: begin
                        if (any_req) begin
                            state    <= ST_WAIT;
                            lat_cnt  <= 2'h1;
                            lat_long <= instr.multi;
                        end
                    end
                    ST_WAIT: begin
                        if (!any_req || int_enter) begin
                            state <= ST_IDLE;
                        end else if (lat_cnt != LAT_LONG) begin
                            lat_cnt <= lat_cnt + 2'h1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    wire        setup   = psel & ~penable & ~pready;
    wire        wr_acc  = psel & penable & pready & pwrite;
    wire        hit     = paddr == OFF_ENABLE_ONE | paddr == OFF_ENABLE_TWO
                          | paddr == OFF_REQ_FLAGS | paddr == OFF_STATUS | paddr == OFF_PC;
    wire [31:0] status  = {26'h0, ei_arm, gie, bank, sp};
    wire [31:0] rd_mux  =
        (paddr == OFF_ENABLE_ONE) ? {28'h0, enable_group_one} :
        (paddr == OFF_ENABLE_TWO) ? {28'h0, enable_group_two} :
        (paddr == OFF_REQ_FLAGS)  ? {24'h0, req_flag} :
        (paddr == OFF_STATUS)     ? status :
        (paddr == OFF_PC)         ? {18'h0, pc} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            prdata           <= '0;
            enable_group_one <= '0;
            enable_group_two <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
            if (wr_acc && paddr == OFF_ENABLE_ONE) begin
                enable_group_one <= pwdata[GRP_W-1:0];
            end
            if (wr_acc && paddr == OFF_ENABLE_TWO) begin
                enable_group_two <= pwdata[GRP_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_stack_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        do_push && sp == 3'h7 |=> sp == 3'h0)
        else $error("stack level did not wrap");
    a_call_push: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_CALL |=> pc == $past(instr.target) && top == $past(pc_step))
        else $error("call did not push return address");
    a_int_gate: assert property (@(posedge pclk) disable iff (!presetn)
        int_enter |-> gie && (req_flag[serve] & en_bits[serve]))
        else $error("interrupt taken without all conditions");
    a_int_gie_clr: assert property (@(posedge pclk) disable iff (!presetn)
        int_enter |=> !gie && int_taken)
        else $error("global enable not cleared on entry");
    a_ei_delay: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_EI && !gie |=> !gie)
        else $error("enable acted without delay");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (req_flag & $past(req_flag & ~clr_mask)) == $past(req_flag & ~clr_mask))
        else $error("request flag lost");
    a_vector_pc: assert property (@(posedge pclk) disable iff (!presetn)
        int_taken |-> pc >= 14'h0080 && pc <= 14'h00ff && !pc[0])
        else $error("vector outside page one upper half");
    a_int_latency: assert property (@(posedge pclk) disable iff (!presetn)
        int_enter |-> lat_cnt >= 2'h2)
        else $error("interrupt entered too early");
    a_page_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_STEP && instr.len == 2'h1 && pc[6:0] == 7'h7f
        |=> pc[6:0] == 7'h00 && pc[13:7] == $past(pc[13:7]) + 7'h01)
        else $error("page crossing wrong");
    a_table_data: assert property (@(posedge pclk) disable iff (!presetn)
        tbl_done |=> table_valid && table_data == $past(rom_word[7:0]))
        else $error("table data wrong");
    a_ctx_save: assert property (@(posedge pclk) disable iff (!presetn)
        int_enter |=> ctx_save.skip == $past(cur_ctx.skip) && ctx_save.dp == $past(dp))
        else $error("context not saved");
    a_serve_clear: assert property (@(posedge pclk) disable iff (!presetn)
        int_enter && src_event == '0 |=> (req_flag & ~$past(req_flag)) == '0
        && $countones(req_flag) + 1 == $countones($past(req_flag)))
        else $error("entry cleared wrong request flags");
    a_di_clear: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_DI |=> !gie && !ei_arm)
        else $error("disable left interrupts armed");
    a_skip_mode: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_SKIP_TEST && en_bits[instr.src] |=> !skip_taken)
        else $error("skip taken on enabled source");
    a_ctx_return: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_INT_RETURN |=> ctx_restore_valid && ctx_restore == $past(ctx_save)
        && pc == $past(top) && dp == $past(ctx_save.dp))
        else $error("interrupt return did not restore");
    a_ctx_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !int_enter |=> $stable(ctx_save))
        else $error("context changed outside entry");
    a_page2_call: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_PAGE2_CALL |=> pc[13:7] == 7'h02)
        else $error("page two call left page two");
    a_table_bank: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_TABLE_REF |=> pc[13] == $past(bank) && tbl_pending)
        else $error("table reference ignored bank");
    a_level_read: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_READ_SP |=> sp_level == $past(sp))
        else $error("level read wrong");
    a_bit_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        exec |=> $onehot(ram_bit_mask))
        else $error("bit mask not one hot");
    a_pc_tick: assert property (@(posedge pclk) disable iff (!presetn)
        !mc_tick |=> $stable(pc))
        else $error("pc moved between machine cycles");

endmodule

// *** rtl/prsi_pkg.sv ***
package prsi_pkg;

    localparam int PC_W        = 14;
    localparam int IN_PAGE_W   = 7;
    localparam int PAGE_W      = PC_W - IN_PAGE_W;
    localparam int SP_W        = 3;
    localparam int STACK_DEPTH = 8;
    localparam int NUM_SRC     = 8;
    localparam int SRC_W       = 3;
    localparam int ROM_W       = 10;
    localparam int TBL_W       = 8;
    localparam int RAM_W       = 4;
    localparam int GRP_W       = 4;
    localparam int TBL_PAGE_W  = 6;
    localparam int APB_AW      = 8;

    localparam logic [PC_W-1:0] PC_RESET    = 14'h0000;
    localparam logic [PC_W-1:0] VECTOR_BASE = 14'h0080;
    localparam logic [PC_W-1:0] PAGE2_BASE  = 14'h0100;
    localparam logic [SP_W-1:0] SP_RESET    = 3'h7;
    localparam logic [1:0]      LAT_SHORT   = 2'h2;
    localparam logic [1:0]      LAT_LONG    = 2'h3;

    localparam logic [APB_AW-1:0] OFF_ENABLE_ONE = 8'h00;
    localparam logic [APB_AW-1:0] OFF_ENABLE_TWO = 8'h04;
    localparam logic [APB_AW-1:0] OFF_REQ_FLAGS  = 8'h08;
    localparam logic [APB_AW-1:0] OFF_STATUS     = 8'h0c;
    localparam logic [APB_AW-1:0] OFF_PC         = 8'h10;
    localparam int STAT_SP_LSB  = 0;
    localparam int STAT_BANK    = 3;
    localparam int STAT_GIE     = 4;
    localparam int STAT_EI_ARM  = 5;

    typedef enum logic [3:0] {
        OP_STEP = 4'h0, OP_BRANCH = 4'h1, OP_CALL = 4'h2, OP_PAGE2_CALL = 4'h3,
        OP_RETURN = 4'h4, OP_INT_RETURN = 4'h5, OP_TABLE_REF = 4'h6, OP_EI = 4'h7,
        OP_DI = 4'h8, OP_SET_BANK = 4'h9, OP_CLR_BANK = 4'ha, OP_READ_SP = 4'hb,
        OP_SKIP_TEST = 4'hc, OP_LOAD_DP = 4'hd
    } prsi_op_t;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} prsi_state_t;

    typedef struct packed {
        logic [0:0] z;
        logic [3:0] x;
        logic [3:0] y;
    } prsi_dp_t;

    typedef struct packed {
        prsi_dp_t   dp;
        logic       carry;
        logic       skip;
        logic [3:0] acc;
        logic [3:0] breg;
    } prsi_ctx_t;

    typedef struct packed {
        prsi_op_t        op;
        logic [1:0]      len;
        logic            multi;
        logic [PC_W-1:0] target;
        logic [5:0]      tbl_page;
        logic [6:0]      tbl_addr;
        logic [2:0]      src;
        logic [1:0]      bit_idx;
        prsi_dp_t        dp;
    } prsi_instr_t;

endpackage

// *** bench/prsi_program_model.sv ***
`timescale 1ns/1ps
module prsi_program_model
    import prsi_pkg::*;
(
    input  wire logic [0:0]         pclk,      // clock
    input  wire logic               presetn,   // async reset, low
    input  wire logic [PC_W-1:0]    pc,        // fetch address
    input  wire logic [NUM_SRC-1:0] raise,     // source conditions
    output logic                    mc_tick,   // machine cycle enable
    output logic      [NUM_SRC-1:0] src_event, // activation pulses
    output logic      [ROM_W-1:0]   rom_word   // program word at pc
);
    logic [1:0]         div;
    logic [NUM_SRC-1:0] raise_q;

    // one machine cycle every fourth clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div     <= 2'h0;
            raise_q <= '0;
        end else begin
            div     <= div + 2'h1;
            raise_q <= raise;
        end
    end

    assign mc_tick   = (div == 2'h3);
    assign src_event = raise & ~raise_q;
    // word pattern differs at every address within 1024 words; only pc[ROM_W-1:0] is used
    assign rom_word  = pc[ROM_W-1:0] ^ 10'h2a5;
endmodule

// *** bench/test_program_sequencer_interrupt.sv ***
`timescale 1ns/1ps
module test_program_sequencer_interrupt
    import prsi_pkg::*;
;
    typedef struct packed {
        prsi_op_t   op;
        logic [1:0] len;
        logic [13:0] target;
        logic [13:0] exp_pc;
    } prsi_row_t;

    prsi_row_t   rows [8] = '{
        '{OP_STEP, 2'h1, 14'h0000, 14'h0001}, '{OP_STEP, 2'h2, 14'h0000, 14'h0003},
        '{OP_BRANCH, 2'h1, 14'h007f, 14'h007f}, '{OP_STEP, 2'h1, 14'h0000, 14'h0080},
        '{OP_PAGE2_CALL, 2'h1, 14'h0105, 14'h0105}, '{OP_CALL, 2'h1, 14'h2000, 14'h2000},
        '{OP_RETURN, 2'h1, 14'h0000, 14'h0106}, '{OP_RETURN, 2'h1, 14'h0000, 14'h0081}};
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, mc_tick, instr_valid;
    logic [7:0]  paddr, src_event, raise, table_data;
    logic [31:0] pwdata, prdata, rd;
    prsi_instr_t instr, i;
    prsi_ctx_t   cur_ctx, ctx_restore;
    prsi_dp_t    ram_addr;
    logic [9:0]  rom_word;
    logic [13:0] pc, pc_b, t;
    logic [3:0]  ram_bit_mask;
    logic [2:0]  sp_level;
    logic        table_valid, skip_taken, ctx_restore_valid, int_taken, err;
    int          errors = 0;
    int          ints = 0;
    int          n0, steps;
    int          checks_done = 0;

    prsi_sequencer prsi_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mc_tick(mc_tick), .instr_valid(instr_valid), .instr(instr),
        .cur_ctx(cur_ctx), .src_event(src_event), .rom_word(rom_word), .pc(pc),
        .ram_addr(ram_addr), .ram_bit_mask(ram_bit_mask), .table_data(table_data),
        .table_valid(table_valid), .skip_taken(skip_taken), .sp_level(sp_level),
        .ctx_restore(ctx_restore), .ctx_restore_valid(ctx_restore_valid),
        .int_taken(int_taken));
    prsi_program_model prsi_program_model_i (
        .pclk(pclk), .presetn(presetn), .pc(pc), .raise(raise), .mc_tick(mc_tick),
        .src_event(src_event), .rom_word(rom_word));

    always #20 pclk = ~pclk;
    always @(posedge pclk) if (int_taken === 1'b1) ints <= ints + 1;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // present one instruction and hold it until a machine cycle takes it
    task exec(input prsi_instr_t n);
        @(posedge pclk);
        instr       <= n;
        instr_valid <= 1'b1;
        do @(posedge pclk); while (mc_tick !== 1'b1);
        instr_valid <= 1'b0;
        #1;
    endtask

    function automatic prsi_instr_t mk(prsi_op_t op, logic [13:0] tg);
        prsi_instr_t n;
        n        = '0;
        n.op     = op;
        n.len    = 2'h1;
        n.target = tg;
        return n;
    endfunction

    // keep stepping until entry; the step on the entry tick is dropped
    // steps: the one raising the global enable, two or three ticks more, then the dropped one
    task wait_int(input logic m, input int want);
        n0      = ints;
        i       = mk(OP_STEP, '0);
        i.multi = m;
        for (steps = 0; steps < 6 && ints == n0; steps++) begin
            pc_b = pc;
            exec(i);
            repeat (2) @(posedge pclk);
            #1;
        end
        chk(ints - n0, 32'h1);
        chk(steps, want);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, instr_valid} = '0;
        {paddr, pwdata, raise, instr, cur_ctx, i} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(32'(pc), 32'(PC_RESET));
        apb(1'b0, OFF_STATUS, '0);
        chk(rd, 32'h7);
        foreach (rows[r]) begin
            i     = mk(rows[r].op, rows[r].target);
            i.len = rows[r].len;
            exec(i);
            chk(32'(pc), 32'(rows[r].exp_pc));
        end
        for (int k = 0; k < 9; k++) exec(mk(OP_CALL, 14'h0200 + 14'(k * 16)));
        exec(mk(OP_READ_SP, '0));
        chk(32'(sp_level), 32'h0);
        for (int k = 0; k < 9; k++) begin
            exec(mk(OP_RETURN, '0));
            if (k == 0 || k == 8) chk(32'(pc), 32'h0271);
        end
        for (int b = 1; b >= 0; b--) begin
            exec(mk(b ? OP_SET_BANK : OP_CLR_BANK, '0));
            i          = mk(OP_TABLE_REF, '0);
            i.tbl_page = 6'h05;
            i.tbl_addr = 7'h13;
            t          = {b[0], 6'h05, 7'h13};
            pc_b       = pc;
            exec(i);
            chk(32'(pc), 32'(t));
            for (int k = 0; k < 12 && table_valid !== 1'b1; k++) @(posedge pclk);
            chk(32'(table_data), 32'(t[7:0] ^ 8'ha5));
            #1;
            chk(32'(pc), 32'(pc_b + 14'h1));
        end
        i         = mk(OP_LOAD_DP, '0);
        i.dp      = 9'h1a5;
        i.bit_idx = 2'h2;
        exec(i);
        chk(32'(ram_addr), 32'h1a5);
        chk(32'(ram_bit_mask), 32'h4);
        apb(1'b1, OFF_ENABLE_ONE, 32'h6);
        @(posedge pclk);
        raise <= 8'h26;
        @(posedge pclk);
        raise <= 8'h00;
        apb(1'b0, OFF_REQ_FLAGS, '0);
        chk(rd, 32'h26);
        for (int s = 5; s >= 1; s -= 4) begin
            i     = mk(OP_SKIP_TEST, '0);
            i.src = 3'(s);
            exec(i);
            chk(32'(skip_taken), 32'(s == 5));
        end
        n0 = ints;
        exec(mk(OP_EI, '0));
        exec(mk(OP_DI, '0));
        repeat (2) exec(mk(OP_STEP, '0));
        apb(1'b0, OFF_STATUS, '0);
        chk(32'(rd[5:4]), 32'h0);
        chk(ints - n0, 32'h0);
        apb(1'b0, OFF_REQ_FLAGS, '0);
        chk(rd, 32'h06);
        cur_ctx <= '{dp: '0, carry: 1'b1, skip: 1'b1, acc: 4'h9, breg: 4'h3};
        exec(mk(OP_EI, '0));
        apb(1'b0, OFF_STATUS, '0);
        chk(32'(rd[5:4]), 32'h2);
        wait_int(1'b0, 4);
        chk(32'(pc), 32'(VECTOR_BASE + 14'h2));
        apb(1'b0, OFF_REQ_FLAGS, '0);
        chk(rd, 32'h04);
        apb(1'b0, OFF_STATUS, '0);
        chk(32'(rd[4]), 32'h0);
        cur_ctx <= '0;
        exec(mk(OP_INT_RETURN, '0));
        chk(32'(ctx_restore_valid), 32'h1);
        chk(32'(ctx_restore), 32'({9'h1a5, 1'b1, 1'b1, 4'h9, 4'h3}));
        chk(32'(pc), 32'(pc_b));
        exec(mk(OP_EI, '0));
        wait_int(1'b1, 5);
        chk(32'(pc), 32'(VECTOR_BASE + 14'h4));
        apb(1'b1, OFF_ENABLE_TWO, 32'hffffffff);
        apb(1'b0, OFF_ENABLE_TWO, '0);
        chk(rd, 32'hf);
        apb(1'b1, OFF_PC, 32'h1234);
        apb(1'b0, OFF_PC, '0);
        chk(rd, 32'(VECTOR_BASE + 14'h4));
        apb(1'b0, 8'h14, '0);
        chk({rd[30:0], err}, 32'h1);
        // reset again in mid-run: pc, level and enables return to reset values
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(32'(pc), 32'(PC_RESET));
        apb(1'b0, OFF_STATUS, '0);
        chk(rd, 32'h7);
        apb(1'b0, OFF_ENABLE_TWO, '0);
        chk(rd, 32'h0);
        end_sim;
    end

    // the sequence needs a few hundred cycles; allow far more
    initial begin
        #800000;
        errors++;
        end_sim;
    end
endmodule
